/* logic/aecu_cnt_if.sv */
// Purpose: control and status bundle between the top and one counter
// Assumes: one instance per counter
// Notes: wrap is combinational and valid in the cycle of the increment
`timescale 1ns/1ps
interface aecu_cnt_if #(parameter int unsigned W = 8);
    logic inc;
    logic clr;
    logic wrap;
    logic [W-1:0] count;
    modport ctl (output inc, output clr, input wrap, input count);
    modport cnt (input inc, input clr, output wrap, output count);
endinterface

/* logic/aecu_counter8.sv */
// Purpose: one up-counter with held clear and wrap indication
// Assumes: inc is a one-cycle pulse on the system clock
// Notes: clear wins over increment
`timescale 1ns/1ps
module aecu_counter8 #(
    parameter int unsigned W = 8
) (
    input wire logic clock,
    input wire logic nrst,
    input wire logic ce,
    aecu_cnt_if.cnt port_if
);
    logic [W-1:0] count_r;

    // count, or hold at zero while cleared
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            count_r <= W'(aecu_pkg::RST_COUNT);
        end else if (ce) begin
            if (port_if.clr) begin
                count_r <= '0;
            end else if (port_if.inc) begin
                count_r <= W'(count_r + 1'b1);
            end
        end
    end

    // wrap marks the increment that returns the count to zero
    assign port_if.wrap = port_if.inc & ~port_if.clr & (count_r == {W{1'b1}});
    assign port_if.count = count_r;
endmodule

/* logic/aecu_edge_det.sv */
// Purpose: synchronise one event pin and detect the selected edge
// Assumes: pin widths of at least two system clock periods
// Notes: event_pulse is one cycle long, three cycles after the pin edge
`timescale 1ns/1ps
module aecu_edge_det (
    input wire logic clock,
    input wire logic nrst,
    input wire logic ce,
    input wire logic pin_async,
    input wire logic [1:0] mode,
    output logic level,
    output logic event_pulse
);
    logic sync1_r;
    logic sync2_r;
    logic prev_r;
    logic evt_r;
    logic rise;
    logic fall;

    // two-flop synchroniser, first flop feeds only the second
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            sync1_r <= 1'b0;
            sync2_r <= 1'b0;
            prev_r <= 1'b0;
        end else if (ce) begin
            sync1_r <= pin_async;
            sync2_r <= sync1_r;
            prev_r <= sync2_r;
        end
    end

    assign rise = sync2_r & ~prev_r;
    assign fall = ~sync2_r & prev_r;

    // pick the edge; both codes above rise count both edges
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            evt_r <= 1'b0;
        end else if (ce) begin
            if (mode == aecu_pkg::EDGE_FALL) begin
                evt_r <= fall;
            end else if (mode == aecu_pkg::EDGE_RISE) begin
                evt_r <= rise;
            end else begin
                evt_r <= rise | fall;
            end
        end
    end

    assign level = prev_r;
    assign event_pulse = evt_r;
endmodule

/* logic/aecu_pkg.sv */
// Purpose: shared constants of the asynchronous event counter unit
// Assumes: 8-bit register port, three event pins sampled by the system clock
// Notes: offsets are register indices on the plain register port
package aecu_pkg;

    // register port geometry
    localparam int unsigned DATA_W = 8;
    localparam int unsigned ADDR_W = 3;

    // register offsets
    localparam logic [2:0] OFS_EDGE_SELECT = 3'h0;
    localparam logic [2:0] OFS_CLOCK_CONTROL = 3'h1;
    localparam logic [2:0] OFS_CONTROL_STATUS = 3'h2;
    localparam logic [2:0] OFS_COUNT_UPPER = 3'h3;
    localparam logic [2:0] OFS_COUNT_LOWER = 3'h4;
    localparam logic [2:0] OFS_IRQ_CONTROL = 3'h5;
    localparam logic [2:0] OFS_STANDBY = 3'h6;

    // event pins, index into the sampled pin vector
    localparam int unsigned PIN_N = 3;
    localparam int unsigned PIN_UPPER = 0;
    localparam int unsigned PIN_LOWER = 1;
    localparam int unsigned PIN_IRQ = 2;

    // edge select: one two-bit field per pin, pin i at bit i*EDGE_FLD_W
    localparam int unsigned EDGE_FLD_W = 2;
    localparam logic [1:0] EDGE_FALL = 2'h0;
    localparam logic [1:0] EDGE_RISE = 2'h1;
    localparam logic [1:0] EDGE_BOTH = 2'h2;

    // control/status bits
    localparam int unsigned CS_UPPER_OVF = 7;
    localparam int unsigned CS_LOWER_OVF = 6;
    localparam int unsigned CS_UPPER_CLK_SEL = 5;
    localparam int unsigned CS_UPPER_EN = 4;
    localparam int unsigned CS_LOWER_EN = 3;
    localparam int unsigned CS_UPPER_RUN = 2;
    localparam int unsigned CS_LOWER_RUN = 1;
    localparam logic [7:0] CS_STORE_MASK = 8'h3E;

    // interrupt control bits
    localparam int unsigned IR_COUNTER_FLAG = 0;
    localparam int unsigned IR_COUNTER_EN = 1;
    localparam int unsigned IR_PIN_FLAG = 2;
    localparam int unsigned IR_PIN_EN = 3;

    // standby bit
    localparam int unsigned SB_STANDBY = 0;

    // reset values
    localparam logic [7:0] RST_EDGE_SELECT = 8'h00;
    localparam logic [7:0] RST_CONTROL_STATUS = 8'h00;
    localparam logic [7:0] RST_COUNT = 8'h00;
    localparam logic [7:0] RST_IRQ_CONTROL = 8'h00;
    localparam logic [7:0] RST_STANDBY = 8'h00;

endpackage

/* logic/aecu_top.sv */
// Purpose: asynchronous event counter unit, two 8-bit counters with cascade
// Assumes: event pins are asynchronous and slower than a quarter of clock
// Notes: registers reached on a plain port, read data one cycle later
`timescale 1ns/1ps

// How it works
// - count asynchronous pin events, not tied to bus
// - cascaded pair counts 65,536 events then wraps
// - two independent 8-bit counters, one per pin
// - software clears and halts counters via control/status
// - overflow sets the counter interrupt flag automatically
// - standby stops this counter unit alone
// - edge select register picks edge per pin
// - control/status register 8-bit, resets to zero
// - upper clock: upper pin or lower overflow
// - upper counter read-only, clearable, resets zero
// - lower counter read-only, lower pin, resets zero
// - interrupt flag sticks until software writes zero
// - request forwarded only while enable bit set
// - 16-bit wrap sets upper overflow, both zero
// - upper clock select resets to cascade mode
module aecu_top (
    input wire logic clock,
    input wire logic nrst,
    input wire logic ce,
    input wire logic [aecu_pkg::ADDR_W-1:0] addr,
    input wire logic [aecu_pkg::DATA_W-1:0] wr_data,
    input wire logic wr_en,
    input wire logic rd_en,
    output logic [aecu_pkg::DATA_W-1:0] rd_data,
    input wire logic upper_event_pin,
    input wire logic lower_event_pin,
    input wire logic counter_irq_pin,
    output logic irq
);
    localparam int unsigned DW = aecu_pkg::DATA_W;

    // software-visible state
    logic [DW-1:0] edge_select_r;
    logic [DW-1:0] control_r;
    logic upper_ovf_r;
    logic lower_ovf_r;
    logic counter_irq_flag_r;
    logic counter_irq_enable_r;
    logic pin_irq_flag_r;
    logic pin_irq_enable_r;
    logic standby_r;

    // registered outputs
    logic [DW-1:0] rd_data_r;
    logic [DW-1:0] rd_data_nxt;
    logic irq_r;
    logic irq_nxt;

    // sampled pins
    logic [aecu_pkg::PIN_N-1:0] pin_raw;
    logic [aecu_pkg::PIN_N-1:0] pin_level;
    logic [aecu_pkg::PIN_N-1:0] pin_event;

    // decoded bus accesses
    logic wr_edge;
    logic wr_control;
    logic wr_irq;
    logic wr_standby;

    // counting control
    logic cascade;
    logic counting;
    logic upper_ovf_evt;
    logic lower_ovf_evt;
    logic counter_ovf_evt;

    aecu_cnt_if #(.W(DW)) lower_if ();
    aecu_cnt_if #(.W(DW)) upper_if ();

    // pins gathered so one generate loop serves all three
    assign pin_raw[aecu_pkg::PIN_UPPER] = upper_event_pin;
    assign pin_raw[aecu_pkg::PIN_LOWER] = lower_event_pin;
    assign pin_raw[aecu_pkg::PIN_IRQ] = counter_irq_pin;

    // each pin is synchronised before any logic looks at it; edges are
    // found on the system clock, so the bus side never waits on a pin
    for (genvar gi = 0; gi < aecu_pkg::PIN_N; gi++) begin : g_pin
        aecu_edge_det u_det (
            .clock(clock),
            .nrst(nrst),
            .ce(ce),
            .pin_async(pin_raw[gi]),
            .mode(edge_select_r[gi*aecu_pkg::EDGE_FLD_W +: aecu_pkg::EDGE_FLD_W]),
            .level(pin_level[gi]),
            .event_pulse(pin_event[gi])
        );
    end

    // write decode; standby holds edge select and control/status as well
    assign wr_edge = wr_en & (addr == aecu_pkg::OFS_EDGE_SELECT) & ~standby_r;
    assign wr_control = wr_en & (addr == aecu_pkg::OFS_CONTROL_STATUS) & ~standby_r;
    assign wr_irq = wr_en & (addr == aecu_pkg::OFS_IRQ_CONTROL);
    assign wr_standby = wr_en & (addr == aecu_pkg::OFS_STANDBY);

    // clock select low means the upper counter eats lower overflows
    assign cascade = ~control_r[aecu_pkg::CS_UPPER_CLK_SEL];
    assign counting = ~standby_r;

    // lower counter: lower pin only
    assign lower_if.inc = counting & control_r[aecu_pkg::CS_LOWER_EN]
        & pin_event[aecu_pkg::PIN_LOWER];
    assign lower_if.clr = ~control_r[aecu_pkg::CS_LOWER_RUN];

    // upper counter: lower wrap in cascade, else its own pin
    assign upper_if.inc = counting & control_r[aecu_pkg::CS_UPPER_EN]
        & (cascade ? lower_if.wrap : pin_event[aecu_pkg::PIN_UPPER]);
    assign upper_if.clr = ~control_r[aecu_pkg::CS_UPPER_RUN];

    // in cascade the upper wrap only happens with the lower wrap, so it
    // is the 16-bit overflow: both counters land on zero together
    assign upper_ovf_evt = upper_if.wrap;
    assign lower_ovf_evt = ~cascade & lower_if.wrap;
    assign counter_ovf_evt = upper_ovf_evt | lower_ovf_evt;

    aecu_counter8 #(.W(DW)) u_lower (
        .clock(clock),
        .nrst(nrst),
        .ce(ce),
        .port_if(lower_if)
    );

    aecu_counter8 #(.W(DW)) u_upper (
        .clock(clock),
        .nrst(nrst),
        .ce(ce),
        .port_if(upper_if)
    );

    // edge select, plain read/write
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            edge_select_r <= aecu_pkg::RST_EDGE_SELECT;
        end else if (ce) begin
            if (wr_edge) begin
                edge_select_r <= wr_data;
            end
        end
    end

    // stored control bits; reset leaves cascade mode and both counters
    // held at zero, so software must release them before counting
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            control_r <= aecu_pkg::RST_CONTROL_STATUS;
        end else if (ce) begin
            if (wr_control) begin
                // the write lands unless standby is set, pin activity cannot block it
                control_r <= wr_data & aecu_pkg::CS_STORE_MASK;
            end
        end
    end

    // upper overflow flag: set wins over a software write of zero
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            upper_ovf_r <= 1'b0;
        end else if (ce) begin
            if (upper_ovf_evt) begin
                upper_ovf_r <= 1'b1;
            end else if (wr_control && !wr_data[aecu_pkg::CS_UPPER_OVF]) begin
                upper_ovf_r <= 1'b0;
            end
        end
    end

    // lower overflow flag, only meaningful in independent mode
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            lower_ovf_r <= 1'b0;
        end else if (ce) begin
            if (lower_ovf_evt) begin
                lower_ovf_r <= 1'b1;
            end else if (wr_control && !wr_data[aecu_pkg::CS_LOWER_OVF]) begin
                lower_ovf_r <= 1'b0;
            end
        end
    end

    // counter interrupt flag: sticky, cleared only by writing zero
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            counter_irq_flag_r <= aecu_pkg::RST_IRQ_CONTROL[aecu_pkg::IR_COUNTER_FLAG];
        end else if (ce) begin
            if (counter_ovf_evt) begin
                counter_irq_flag_r <= 1'b1;
            end else if (wr_irq && !wr_data[aecu_pkg::IR_COUNTER_FLAG]) begin
                counter_irq_flag_r <= 1'b0;
            end
        end
    end

    // pin interrupt flag on the selected edge of the interrupt pin
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            pin_irq_flag_r <= aecu_pkg::RST_IRQ_CONTROL[aecu_pkg::IR_PIN_FLAG];
        end else if (ce) begin
            if (pin_event[aecu_pkg::PIN_IRQ] && counting) begin
                pin_irq_flag_r <= 1'b1;
            end else if (wr_irq && !wr_data[aecu_pkg::IR_PIN_FLAG]) begin
                pin_irq_flag_r <= 1'b0;
            end
        end
    end

    // interrupt enables
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            counter_irq_enable_r <= aecu_pkg::RST_IRQ_CONTROL[aecu_pkg::IR_COUNTER_EN];
            pin_irq_enable_r <= aecu_pkg::RST_IRQ_CONTROL[aecu_pkg::IR_PIN_EN];
        end else if (ce) begin
            if (wr_irq) begin
                counter_irq_enable_r <= wr_data[aecu_pkg::IR_COUNTER_EN];
                pin_irq_enable_r <= wr_data[aecu_pkg::IR_PIN_EN];
            end
        end
    end

    // module standby; always writable so software can wake the unit
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            standby_r <= aecu_pkg::RST_STANDBY[aecu_pkg::SB_STANDBY];
        end else if (ce) begin
            if (wr_standby) begin
                standby_r <= wr_data[aecu_pkg::SB_STANDBY];
            end
        end
    end

    // request gated by its enable; flags keep counting regardless
    always_comb begin
        irq_nxt = (counter_irq_flag_r & counter_irq_enable_r)
            | (pin_irq_flag_r & pin_irq_enable_r);
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            irq_r <= 1'b0;
        end else if (ce) begin
            irq_r <= irq_nxt;
        end
    end

    // read mux; counts are read live, so a read while events arrive may
    // see a torn 16-bit value unless both enables are cleared first
    always_comb begin
        rd_data_nxt = '0;
        if (rd_en) begin
            case (addr)
                aecu_pkg::OFS_EDGE_SELECT: begin
                    rd_data_nxt = edge_select_r;
                end
                aecu_pkg::OFS_CLOCK_CONTROL: begin
                    rd_data_nxt[aecu_pkg::PIN_N-1:0] = pin_level;
                    rd_data_nxt[aecu_pkg::PIN_N] = cascade;
                end
                aecu_pkg::OFS_CONTROL_STATUS: begin
                    rd_data_nxt = control_r;
                    rd_data_nxt[aecu_pkg::CS_UPPER_OVF] = upper_ovf_r;
                    rd_data_nxt[aecu_pkg::CS_LOWER_OVF] = lower_ovf_r;
                end
                aecu_pkg::OFS_COUNT_UPPER: begin
                    rd_data_nxt = upper_if.count;
                end
                aecu_pkg::OFS_COUNT_LOWER: begin
                    rd_data_nxt = lower_if.count;
                end
                aecu_pkg::OFS_IRQ_CONTROL: begin
                    rd_data_nxt[aecu_pkg::IR_COUNTER_FLAG] = counter_irq_flag_r;
                    rd_data_nxt[aecu_pkg::IR_COUNTER_EN] = counter_irq_enable_r;
                    rd_data_nxt[aecu_pkg::IR_PIN_FLAG] = pin_irq_flag_r;
                    rd_data_nxt[aecu_pkg::IR_PIN_EN] = pin_irq_enable_r;
                end
                aecu_pkg::OFS_STANDBY: begin
                    rd_data_nxt[aecu_pkg::SB_STANDBY] = standby_r;
                end
                default: begin
                    rd_data_nxt = '0;
                end
            endcase
        end
    end

    // read data stands for exactly the cycle after the strobe
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            rd_data_r <= '0;
        end else if (ce) begin
            rd_data_r <= rd_data_nxt;
        end
    end

    assign rd_data = rd_data_r;
    assign irq = irq_r;
endmodule

/* verif/aecu_event_src.sv */
// Purpose: far-side model, an event source driving the three event pins
// Assumes: pins idle low between bursts, link period 160 ns
// Notes: bursts start 7 ns after the call, off the bench clock grid, so edges never line up
`timescale 1ns/1ps
module aecu_event_src (
    output logic upper_event_pin,
    output logic lower_event_pin,
    output logic counter_irq_pin
);
    // pins start low so the first edge seen is a rising one
    initial begin
        upper_event_pin = 1'b0;
        lower_event_pin = 1'b0;
        counter_irq_pin = 1'b0;
    end

    // n full pulses on every pin set in sel, no relation to the system clock
    task automatic burst(input logic [2:0] sel, input int n);
        #7;
        repeat (n) begin
            upper_event_pin = sel[0];
            lower_event_pin = sel[1];
            counter_irq_pin = sel[2];
            #80;
            upper_event_pin = 1'b0;
            lower_event_pin = 1'b0;
            counter_irq_pin = 1'b0;
            #80;
        end
    endtask
endmodule

/* verif/aecu_properties.sv */
// Purpose: port-level checker of the event counter unit
// Assumes: ce held high, shadows follow the documented write rules
// Notes: shadows only model software-owned bits, never the counters
`timescale 1ns/1ps
module aecu_properties (
    input wire logic clock,
    input wire logic nrst,
    input wire logic ce,
    input wire logic [2:0] addr,
    input wire logic [7:0] wr_data,
    input wire logic wr_en,
    input wire logic rd_en,
    input wire logic [7:0] rd_data,
    input wire logic upper_event_pin,
    input wire logic lower_event_pin,
    input wire logic counter_irq_pin,
    input wire logic irq
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!nrst);

    logic [7:0] edge_sh_r;
    logic [7:0] cs_sh_r;
    logic [7:0] ie_sh_r;
    logic sb_sh_r;

    // shadows of stored bits; standby blocks edge select and control writes
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            edge_sh_r <= 8'h00;
            cs_sh_r <= 8'h00;
            ie_sh_r <= 8'h00;
            sb_sh_r <= 1'b0;
        end else if (wr_en && ce) begin
            if (addr == aecu_pkg::OFS_EDGE_SELECT && !sb_sh_r) edge_sh_r <= wr_data;
            if (addr == aecu_pkg::OFS_CONTROL_STATUS && !sb_sh_r) cs_sh_r <= wr_data;
            if (addr == aecu_pkg::OFS_IRQ_CONTROL) ie_sh_r <= wr_data;
            if (addr == aecu_pkg::OFS_STANDBY) sb_sh_r <= wr_data[0];
        end
    end

    AST_RD_IDLE: assert property (!$past(rd_en) |-> rd_data == 8'h00)
        else $error("read data not zero outside read cycle");
    AST_UNMAPPED: assert property (rd_en && addr == 3'h7 |=> rd_data == 8'h00)
        else $error("unmapped read not zero");
    AST_EDGE_READBACK: assert property (rd_en && addr == aecu_pkg::OFS_EDGE_SELECT
        |=> rd_data == edge_sh_r) else $error("edge select readback wrong");
    AST_CS_READBACK: assert property (rd_en && addr == aecu_pkg::OFS_CONTROL_STATUS
        |=> rd_data[5:0] == {cs_sh_r[5:1], 1'b0}) else $error("control readback wrong");
    AST_LOWER_CLEARED: assert property (rd_en && addr == aecu_pkg::OFS_COUNT_LOWER
        && !cs_sh_r[1] && !$past(cs_sh_r[1]) |=> rd_data == 8'h00)
        else $error("lower count not held clear");
    AST_UPPER_CLEARED: assert property (rd_en && addr == aecu_pkg::OFS_COUNT_UPPER
        && !cs_sh_r[2] && !$past(cs_sh_r[2]) |=> rd_data == 8'h00)
        else $error("upper count not held clear");
    AST_IRQ_NEEDS_ENABLE: assert property (irq |-> $past(ie_sh_r[1]) || $past(ie_sh_r[3]))
        else $error("irq without enable");
    // the write lands on one edge, the flag drops after it and the
    // registered request one edge later, so the cause sits two samples back
    AST_IRQ_FALL_CAUSE: assert property ($fell(irq)
        |-> $past(wr_en, 2) && ($past(addr, 2) == aecu_pkg::OFS_IRQ_CONTROL))
        else $error("irq dropped without software write");
endmodule

/* verif/testbench.sv */
// Purpose: register-level testbench of the event counter unit
// Assumes: ce tied high, event source model drives the pins
// Notes: 16-bit wrap reached by presetting 0xFF:0xFF in independent mode
`timescale 1ns/1ps
module testbench;
    logic clock = 1'b0;
    logic nrst = 1'b0;
    logic [2:0] addr = 3'h0;
    logic [7:0] wr_data = 8'h00;
    logic wr_en = 1'b0;
    logic rd_en = 1'b0;
    logic [7:0] rd_data;
    logic upper_event_pin;
    logic lower_event_pin;
    logic counter_irq_pin;
    logic irq;
    int miscompares = 0;
    int n_tests = 0;
    logic [1:0] modes [3] = '{aecu_pkg::EDGE_FALL, aecu_pkg::EDGE_RISE, aecu_pkg::EDGE_BOTH};

    always #10 clock = ~clock;

    aecu_top u_aecu_top (.clock(clock), .nrst(nrst), .ce(1'b1), .addr(addr),
        .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data),
        .upper_event_pin(upper_event_pin), .lower_event_pin(lower_event_pin),
        .counter_irq_pin(counter_irq_pin), .irq(irq));
    aecu_event_src u_aecu_event_src (.upper_event_pin(upper_event_pin),
        .lower_event_pin(lower_event_pin), .counter_irq_pin(counter_irq_pin));

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp) begin
            miscompares++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // one-cycle write strobe
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge clock);
        wr_en <= 1'b1;
        addr <= a;
        wr_data <= d;
        @(posedge clock);
        wr_en <= 1'b0;
    endtask

    // one-cycle read strobe, data checked in the following cycle
    task automatic rd(input logic [2:0] a, input logic [7:0] exp);
        @(posedge clock);
        rd_en <= 1'b1;
        addr <= a;
        @(posedge clock);
        rd_en <= 1'b0;
        #1;
        chk(rd_data, exp);
    endtask

    // pin synchroniser latency is a few cycles, let it settle
    task automatic settle();
        repeat (8) @(posedge clock);
    endtask

    task automatic conclude();
        $display("comparisons %0d mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask

    // cut a hang well past the expected few thousand cycles
    initial begin
        #400000;
        miscompares++;
        conclude();
    end

    initial begin
        repeat (20) @(posedge clock);
        nrst <= 1'b1;
        repeat (2) @(posedge clock);
        // reset values, unmapped index included
        foreach (modes[i]) rd(3'(i * 2), 8'h00);
        rd(aecu_pkg::OFS_CLOCK_CONTROL, 8'h08);
        rd(aecu_pkg::OFS_COUNT_UPPER, 8'h00);
        rd(aecu_pkg::OFS_COUNT_LOWER, 8'h00);
        rd(3'h5, 8'h00);
        rd(3'h7, 8'h00);
        // count registers refuse writes
        wr(aecu_pkg::OFS_COUNT_UPPER, 8'hFF);
        wr(aecu_pkg::OFS_COUNT_LOWER, 8'hFF);
        rd(aecu_pkg::OFS_COUNT_UPPER, 8'h00);
        rd(aecu_pkg::OFS_COUNT_LOWER, 8'h00);
        // each edge mode on the lower pin, then halted pulses must not count
        foreach (modes[i]) begin
            wr(aecu_pkg::OFS_CONTROL_STATUS, 8'h00);
            rd(aecu_pkg::OFS_COUNT_LOWER, 8'h00);
            wr(aecu_pkg::OFS_EDGE_SELECT, {4'h0, modes[i], 2'h0});
            wr(aecu_pkg::OFS_CONTROL_STATUS, 8'h1E);
            u_aecu_event_src.burst(3'b010, 3);
            settle();
            wr(aecu_pkg::OFS_CONTROL_STATUS, 8'h06);
            u_aecu_event_src.burst(3'b010, 2);
            settle();
            rd(aecu_pkg::OFS_COUNT_LOWER, (i == 2) ? 8'h06 : 8'h03);
        end
        // independent mode preset to 0xFF on both counters
        wr(aecu_pkg::OFS_CONTROL_STATUS, 8'h00);
        wr(aecu_pkg::OFS_EDGE_SELECT, 8'h15);
        rd(aecu_pkg::OFS_EDGE_SELECT, 8'h15);
        wr(aecu_pkg::OFS_CONTROL_STATUS, 8'h3E);
        u_aecu_event_src.burst(3'b011, 255);
        settle();
        wr(aecu_pkg::OFS_CONTROL_STATUS, 8'h26);
        rd(aecu_pkg::OFS_COUNT_UPPER, 8'hFF);
        rd(aecu_pkg::OFS_COUNT_LOWER, 8'hFF);
        rd(aecu_pkg::OFS_CONTROL_STATUS, 8'h26);
        // cascade: one more lower event wraps the whole 16-bit count
        wr(aecu_pkg::OFS_CONTROL_STATUS, 8'h1E);
        u_aecu_event_src.burst(3'b010, 1);
        settle();
        wr(aecu_pkg::OFS_CONTROL_STATUS, 8'h86);
        rd(aecu_pkg::OFS_COUNT_UPPER, 8'h00);
        rd(aecu_pkg::OFS_COUNT_LOWER, 8'h00);
        rd(aecu_pkg::OFS_CONTROL_STATUS, 8'h86);
        rd(aecu_pkg::OFS_IRQ_CONTROL, 8'h01);
        chk({7'h00, irq}, 8'h00);
        wr(aecu_pkg::OFS_IRQ_CONTROL, 8'h03);
        repeat (2) @(posedge clock);
        #1;
        chk({7'h00, irq}, 8'h01);
        wr(aecu_pkg::OFS_IRQ_CONTROL, 8'h02);
        repeat (2) @(posedge clock);
        #1;
        chk({7'h00, irq}, 8'h00);
        rd(aecu_pkg::OFS_IRQ_CONTROL, 8'h02);
        // event interrupt pin on its rising edge
        u_aecu_event_src.burst(3'b100, 1);
        settle();
        rd(aecu_pkg::OFS_IRQ_CONTROL, 8'h06);
        // standby: writes refused and events ignored
        wr(aecu_pkg::OFS_STANDBY, 8'h01);
        wr(aecu_pkg::OFS_EDGE_SELECT, 8'h00);
        wr(aecu_pkg::OFS_CONTROL_STATUS, 8'h9E);
        rd(aecu_pkg::OFS_EDGE_SELECT, 8'h15);
        rd(aecu_pkg::OFS_CONTROL_STATUS, 8'h86);
        wr(aecu_pkg::OFS_STANDBY, 8'h00);
        wr(aecu_pkg::OFS_CONTROL_STATUS, 8'h9E);
        wr(aecu_pkg::OFS_STANDBY, 8'h01);
        u_aecu_event_src.burst(3'b010, 2);
        settle();
        wr(aecu_pkg::OFS_STANDBY, 8'h00);
        wr(aecu_pkg::OFS_CONTROL_STATUS, 8'h86);
        rd(aecu_pkg::OFS_COUNT_LOWER, 8'h00);
        // independent lower wrap: lower flag and counter irq, upper flag cleared
        wr(aecu_pkg::OFS_CONTROL_STATUS, 8'h2A);
        u_aecu_event_src.burst(3'b010, 256);
        settle();
        wr(aecu_pkg::OFS_CONTROL_STATUS, 8'h62);
        rd(aecu_pkg::OFS_CONTROL_STATUS, 8'h62);
        rd(aecu_pkg::OFS_COUNT_LOWER, 8'h00);
        rd(aecu_pkg::OFS_IRQ_CONTROL, 8'h07);
        chk({7'h00, irq}, 8'h01);
        conclude();
    end
endmodule

bind aecu_top aecu_properties u_aecu_properties (.clock(clock), .nrst(nrst), .ce(ce),
    .addr(addr), .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data),
    .upper_event_pin(upper_event_pin), .lower_event_pin(lower_event_pin),
    .counter_irq_pin(counter_irq_pin), .irq(irq));
